// ===== hw/dbs_pkg.sv
// dual buck sequencer: shared constants, carrier types and helper functions
package dbs_pkg;

	// ============================================================
	// clock and timing
	localparam int          CLK_NS        = 100;    // 10 MHz system clock
	localparam int          DEAD_NS       = 30;     // delay from high-side off to low-side on
	localparam int          DEAD_RAW      = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int          DEAD_CYC      = (DEAD_RAW < 1) ? 1 : DEAD_RAW;
	localparam logic [7:0]  DEAD_LAST     = 8'(DEAD_CYC - 1);
	localparam logic [7:0]  SW_LAST       = 8'h27;  // switching period of 40 clocks
	localparam logic [7:0]  SW_HALF       = 8'h14;  // falling edge of the switching clock
	localparam logic [7:0]  PRECHG_LAST   = 8'h13;  // low-side precharge lasts half a period

	// ============================================================
	// duty and soft ramps
	localparam logic [7:0]  DUTY_MAX      = 8'h10;
	localparam logic [7:0]  DUTY_RST      = 8'h08;

	// ============================================================
	// analog thresholds in millivolts
	localparam logic [12:0] LOCK_TRIP_MV  = 13'h1068; // 4200 mV
	localparam logic [12:0] REARM_MV      = 13'h09C4; // 2500 mV
	localparam logic [12:0] TIED_MARGIN   = 13'h01F4; // 500 mV below the supply
	localparam logic [12:0] LIMIT_SETTING_PIN_DIV      = 13'h000A; // threshold is a tenth of the pin
	localparam logic [12:0] LIMIT_SETTING_PIN_MIN_MV   = 13'h0032; // 50 mV
	localparam logic [12:0] LIMIT_SETTING_PIN_MAX_MV   = 13'h012C; // 300 mV
	localparam logic [12:0] LIMIT_SETTING_PIN_DFLT_MV  = 13'h0064; // 100 mV

	// ============================================================
	// register map and bus answers
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_LIMIT     = 8'h08;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ============================================================
	// carrier types
	typedef struct packed {
		logic high;
		logic low;
		logic idle;
	} dbs_drive_t;

	typedef struct packed {
		logic       lockout;
		logic       run;
		logic       hold_low;
		logic       start;
		logic       over;
		logic       low_off;
		logic [7:0] duty;
	} dbs_phase_ctl_t;

	typedef struct packed {
		logic trip;
		logic rearm;
		logic en;
		logic lvl1;
		logic lvl2;
		logic zero1;
		logic over1;
		logic over2;
		logic loff1;
		logic loff2;
	} dbs_cond_t;

	// ============================================================
	// helpers
	function automatic logic dbs_tied(input logic [12:0] pin_mv, input logic [12:0] vl_mv);
		dbs_tied = ({1'b0, pin_mv} + {1'b0, TIED_MARGIN}) >= {1'b0, vl_mv};
	endfunction : dbs_tied

	function automatic logic [12:0] dbs_limit(input logic [12:0] pin_mv, input logic tied);
		logic [12:0] q;
		q = pin_mv / LIMIT_SETTING_PIN_DIV;
		if (tied)
			dbs_limit = LIMIT_SETTING_PIN_DFLT_MV;
		else if (q < LIMIT_SETTING_PIN_MIN_MV)
			dbs_limit = LIMIT_SETTING_PIN_MIN_MV;
		else if (q > LIMIT_SETTING_PIN_MAX_MV)
			dbs_limit = LIMIT_SETTING_PIN_MAX_MV;
		else
			dbs_limit = q;
	endfunction : dbs_limit

	function automatic logic [7:0] dbs_clamp(input logic [7:0] d);
		dbs_clamp = (d > DUTY_MAX) ? DUTY_MAX : d;
	endfunction : dbs_clamp

	function automatic logic [7:0] dbs_step(input logic [7:0] cur, input logic [7:0] tgt);
		if (cur < tgt)
			dbs_step = cur + 8'h01;
		else if (cur > tgt)
			dbs_step = cur - 8'h01;
		else
			dbs_step = cur;
	endfunction : dbs_step

endpackage : dbs_pkg

// ===== hw/dbs_phase.sv
// dual buck sequencer: gate drive of one regulator with dead time and cycle skip
`timescale 1ns/1ns
module dbs_phase (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// control from the sequencer
	input  wire dbs_pkg::dbs_phase_ctl_t ctl,
	// gate drive
	output      dbs_pkg::dbs_drive_t     drv
);
	import dbs_pkg::*;

	typedef enum logic [2:0] {PH_IDLE, PH_PRECHG, PH_BREAK, PH_HIGH, PH_DEAD, PH_LOW} dbs_ph_t;

	dbs_ph_t    st_reg;
	logic [7:0] cnt_reg;
	logic       high_reg;
	logic       low_reg;
	logic       seen_fall_reg;
	logic       high_end;

	assign high_end = (st_reg == PH_HIGH) && ((cnt_reg >= ctl.duty) || !ctl.run);
	assign drv      = '{high: high_reg, low: low_reg, idle: (st_reg == PH_IDLE)};

	// ============================================================
	// switching state; lockout forces both drives low at once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg   <= PH_IDLE;
			cnt_reg  <= 8'h00;
			high_reg <= 1'b0;
			low_reg  <= 1'b0;
		end else if (ctl.lockout) begin
			st_reg   <= PH_IDLE;
			cnt_reg  <= 8'h00;
			high_reg <= 1'b0;
			low_reg  <= 1'b0;
		end else begin
			case (st_reg)
				PH_IDLE: begin
					high_reg <= 1'b0;
					cnt_reg  <= 8'h00;
					low_reg  <= ctl.hold_low & seen_fall_reg;
					if (ctl.run) begin
						if (seen_fall_reg) begin
							low_reg <= 1'b1;
							st_reg  <= PH_PRECHG;
						end else begin
							st_reg  <= PH_BREAK;
						end
					end
				end
				PH_PRECHG: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg >= PRECHG_LAST) begin
						low_reg <= 1'b0;
						cnt_reg <= 8'h00;
						st_reg  <= PH_BREAK;
					end
				end
				PH_BREAK: begin
					// high side waits for its clock edge and a low side sensed off
					if (!ctl.run) begin
						st_reg <= PH_IDLE;
					end else if (ctl.start && ctl.low_off && !low_reg) begin
						high_reg <= 1'b1;
						cnt_reg  <= 8'h00;
						st_reg   <= PH_HIGH;
					end
				end
				PH_HIGH: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (high_end) begin
						high_reg <= 1'b0;
						cnt_reg  <= 8'h00;
						st_reg   <= PH_DEAD;
					end
				end
				PH_DEAD: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg >= DEAD_LAST) begin
						low_reg <= 1'b1;
						cnt_reg <= 8'h00;
						st_reg  <= PH_LOW;
					end
				end
				PH_LOW: begin
					// over the valley limit the cycle is skipped with low side kept on
					if (!ctl.run) begin
						st_reg <= PH_IDLE;
					end else if (ctl.start && !ctl.over) begin
						low_reg <= 1'b0;
						st_reg  <= PH_BREAK;
					end
				end
				default: st_reg <= PH_IDLE;
			endcase
		end
	end

	// ============================================================
	// first high-side fall after lockout releases the low side
	always_ff @(posedge clk) begin
		if (!rst_n)
			seen_fall_reg <= 1'b1;
		else if (ctl.lockout)
			seen_fall_reg <= 1'b0;
		else if (high_end)
			seen_fall_reg <= 1'b1;
	end

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || ctl.lockout);

	sequence dead_then_low_s;
		!low_reg ##1 low_reg;
	endsequence

	latched_low_a: assert property (!seen_fall_reg |-> !low_reg)
		else $error("low drive on before first high fall");
	no_overlap_a: assert property (!(high_reg && low_reg))
		else $error("both drives on together");
	high_gate_a: assert property ($rose(high_reg) |-> $past(ctl.low_off && !low_reg && ctl.start))
		else $error("high drive on without low sensed off or edge");
	dead_time_a: assert property ($fell(high_reg) |-> dead_then_low_s)
		else $error("dead time after high fall wrong");
	skip_cycle_a: assert property ((st_reg == PH_LOW && ctl.start && ctl.over && ctl.run)
		|=> (!high_reg && low_reg))
		else $error("cycle not skipped at current limit");

endmodule : dbs_phase

// ===== hw/dbs_sequencer.sv
// dual buck sequencer: lockout, start/stop ordering, reset output and register slave
//
// Contract
// - Supply under 4.2V enters lockout and forces both gate drives low.
// - Reset output is held low while lockout is active.
// - Lockout latch clears only once supply falls under 2.5V.
// - After lockout, low drive stays off until the first high drive fall.
// - Enable high runs both regulators; enable low shuts both down.
// - Enable rising starts regulator one while regulator two drives stay off.
// - Regulator two soft-starts only after regulator one soft-start is done.
// - Reset released only with both soft-starts done and both outputs above 90%.
// - Enable low soft-stops in reverse order: regulator two before regulator one.
// - After enable is cycled, regulator one restarts only once its output reaches 0V.
// - After soft-stop completes, low drives are held on.
// - Low drive is the complement of high drive with dead time between.
// - High drive turns on only after low drive is sensed fully off.
// - Low drive turns on a fixed 30ns after high drive turns off; the code turns it on one 100ns clock later.
// - Sense above current limit skips the next cycle, low drive stays on.
// - Adjustable limit is a tenth of the limit pin, 50mV to 300mV.
// - Limit pin tied to supply selects a fixed 100mV limit.
// - At start-up low side conducts first; high side in the next half-cycle; the code precharges 20 clocks, not after a lockout, then waits for its edge.
// - Regulator one high turns on at switching rise, regulator two at fall.
// - Reset goes low whenever either output falls below 90%.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module dbs_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// supply, enable and output monitors
	input  wire logic [12:0] internal_regulator_supply_mv,
	input  wire logic        enable,
	input  wire logic        output_level_one_ok,
	input  wire logic        output_level_two_ok,
	input  wire logic        output_level_one_zero,
	// current limit
	input  wire logic [12:0] limit_setting_pin_one_mv,
	input  wire logic [12:0] limit_setting_pin_two_mv,
	input  wire logic [12:0] current_sense_one_mv,
	input  wire logic [12:0] current_sense_two_mv,
	input  wire logic        low_drive_one_off,
	input  wire logic        low_drive_two_off,
	// gate drives
	output      logic        high_drive_one,
	output      logic        low_drive_one,
	output      logic        high_drive_two,
	output      logic        low_drive_two,
	// open-drain reset output
	output      logic        reset_pin_out,
	output      logic        reset_pin_oe_n,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import dbs_pkg::*;

	typedef enum logic [2:0] {
		SQ_LOCKOUT, SQ_STANDBY, SQ_DRAIN, SQ_START1, SQ_START2, SQ_RUN, SQ_STOP2, SQ_STOP1
	} dbs_seq_t;

	dbs_seq_t       st_reg;
	dbs_cond_t      cond_raw_reg;
	dbs_cond_t      cond_meta_reg;
	dbs_cond_t      cond;
	logic [12:0]    thr1_reg;
	logic [12:0]    thr2_reg;
	logic [7:0]     div_reg;
	logic           tick_rise_reg;
	logic           tick_fall_reg;
	logic           lock_reg;
	logic           trip_q_reg;
	logic           lockout;
	logic [7:0]     ramp1_reg;
	logic [7:0]     ramp2_reg;
	logic [7:0]     duty_reg;
	logic [7:0]     tgt;
	logic           ss_done1;
	logic           ss_done2;
	logic           need_drain_reg;
	logic           stop_done_reg;
	logic           run1;
	logic           run2;
	dbs_phase_ctl_t ctl1;
	dbs_phase_ctl_t ctl2;
	dbs_drive_t     drv1;
	dbs_drive_t     drv2;
	logic           aw_got_reg;
	logic           w_got_reg;
	logic [7:0]     awaddr_q_reg;
	logic [31:0]    wdata_q_reg;
	logic [3:0]     wstrb_q_reg;

	// ============================================================
	// monitors: compare in one stage, then two flops into the clock domain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thr1_reg      <= LIMIT_SETTING_PIN_DFLT_MV;
			thr2_reg      <= LIMIT_SETTING_PIN_DFLT_MV;
			cond_raw_reg  <= '0;
			cond_meta_reg <= '0;
			cond          <= '0;
		end else begin
			thr1_reg <= dbs_limit(limit_setting_pin_one_mv,
				dbs_tied(limit_setting_pin_one_mv, internal_regulator_supply_mv));
			thr2_reg <= dbs_limit(limit_setting_pin_two_mv,
				dbs_tied(limit_setting_pin_two_mv, internal_regulator_supply_mv));
			cond_raw_reg <= '{
				trip:  internal_regulator_supply_mv < LOCK_TRIP_MV,
				rearm: internal_regulator_supply_mv < REARM_MV,
				en:    enable,
				lvl1:  output_level_one_ok,
				lvl2:  output_level_two_ok,
				zero1: output_level_one_zero,
				over1: current_sense_one_mv > thr1_reg,
				over2: current_sense_two_mv > thr2_reg,
				loff1: low_drive_one_off,
				loff2: low_drive_two_off};
			cond_meta_reg <= cond_raw_reg;
			cond          <= cond_meta_reg;
		end
	end

	// ============================================================
	// switching clock: one rise and one fall enable per period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_reg       <= 8'h00;
			tick_rise_reg <= 1'b0;
			tick_fall_reg <= 1'b0;
		end else begin
			div_reg       <= (div_reg >= SW_LAST) ? 8'h00 : div_reg + 8'h01;
			tick_rise_reg <= (div_reg == 8'h00);
			tick_fall_reg <= (div_reg == SW_HALF);
		end
	end

	// ============================================================
	// lockout latch: set by a fall through the trip level, cleared only far below it;
	// a supply still rising through the trip level holds lockout without latching
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_reg   <= 1'b0;
			trip_q_reg <= 1'b1;
		end else begin
			trip_q_reg <= cond.trip;
			if (cond.rearm)
				lock_reg <= 1'b0;
			else if (cond.trip && !trip_q_reg)
				lock_reg <= 1'b1;
		end
	end

	assign lockout  = lock_reg || cond.trip;
	assign tgt      = dbs_clamp(duty_reg);
	assign ss_done1 = (ramp1_reg == tgt);
	assign ss_done2 = (ramp2_reg == tgt);

	// ============================================================
	// sequencer: first on, last off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg         <= SQ_LOCKOUT;
			ramp1_reg      <= 8'h00;
			ramp2_reg      <= 8'h00;
			need_drain_reg <= 1'b0;
			stop_done_reg  <= 1'b0;
		end else if (lockout) begin
			st_reg        <= SQ_LOCKOUT;
			ramp1_reg     <= 8'h00;
			ramp2_reg     <= 8'h00;
			stop_done_reg <= 1'b0;
		end else begin
			case (st_reg)
				SQ_LOCKOUT: st_reg <= SQ_STANDBY;
				SQ_STANDBY: begin
					if (cond.en) begin
						st_reg        <= SQ_DRAIN;
						stop_done_reg <= 1'b0;
					end
				end
				SQ_DRAIN: begin
					// both phases must be idle so regulator two is fully off
					if (!cond.en) begin
						st_reg        <= SQ_STANDBY;
						stop_done_reg <= need_drain_reg;
					end else if ((!need_drain_reg || cond.zero1) && drv1.idle && drv2.idle) begin
						st_reg         <= SQ_START1;
						need_drain_reg <= 1'b0;
					end
				end
				SQ_START1: begin
					if (!cond.en)
						st_reg <= SQ_STOP2;
					else if (ss_done1)
						st_reg <= SQ_START2;
					else if (tick_rise_reg)
						ramp1_reg <= dbs_step(ramp1_reg, tgt);
				end
				SQ_START2: begin
					if (!cond.en)
						st_reg <= SQ_STOP2;
					else if (ss_done2 && ss_done1)
						st_reg <= SQ_RUN;
					if (tick_rise_reg)
						ramp1_reg <= dbs_step(ramp1_reg, tgt);
					if (tick_fall_reg)
						ramp2_reg <= dbs_step(ramp2_reg, tgt);
				end
				SQ_RUN: begin
					if (!cond.en)
						st_reg <= SQ_STOP2;
					if (tick_rise_reg)
						ramp1_reg <= dbs_step(ramp1_reg, tgt);
					if (tick_fall_reg)
						ramp2_reg <= dbs_step(ramp2_reg, tgt);
				end
				SQ_STOP2: begin
					need_drain_reg <= 1'b1;
					if (ramp2_reg == 8'h00)
						st_reg <= SQ_STOP1;
					else if (tick_fall_reg)
						ramp2_reg <= ramp2_reg - 8'h01;
				end
				SQ_STOP1: begin
					if (ramp1_reg == 8'h00) begin
						st_reg        <= SQ_STANDBY;
						stop_done_reg <= 1'b1;
					end else if (tick_rise_reg) begin
						ramp1_reg <= ramp1_reg - 8'h01;
					end
				end
				default: st_reg <= SQ_LOCKOUT;
			endcase
		end
	end

	assign run1 = (st_reg == SQ_START1) || (st_reg == SQ_START2) || (st_reg == SQ_RUN) ||
		(st_reg == SQ_STOP2) || (st_reg == SQ_STOP1);
	assign run2 = (st_reg == SQ_START2) || (st_reg == SQ_RUN) || (st_reg == SQ_STOP2);

	assign ctl1 = '{lockout: lockout, run: run1, hold_low: stop_done_reg, start: tick_rise_reg,
		over: cond.over1, low_off: cond.loff1, duty: ramp1_reg};
	assign ctl2 = '{lockout: lockout, run: run2, hold_low: stop_done_reg, start: tick_fall_reg,
		over: cond.over2, low_off: cond.loff2, duty: ramp2_reg};

	// ============================================================
	// the two gate drivers; their drive flops feed the pins directly
	dbs_phase u_phase_one (
		.clk   (clk),
		.rst_n (rst_n),
		.ctl   (ctl1),
		.drv   (drv1)
	);

	dbs_phase u_phase_two (
		.clk   (clk),
		.rst_n (rst_n),
		.ctl   (ctl2),
		.drv   (drv2)
	);

	assign high_drive_one = drv1.high;
	assign low_drive_one  = drv1.low;
	assign high_drive_two = drv2.high;
	assign low_drive_two  = drv2.low;

	// ============================================================
	// reset output: the pin only ever pulls low, release means enable off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reset_pin_out  <= 1'b0;
			reset_pin_oe_n <= 1'b0;
		end else begin
			reset_pin_out  <= 1'b0;
			reset_pin_oe_n <= !lockout && (st_reg == SQ_RUN) &&
				cond.lvl1 && cond.lvl2 && ss_done1 && ss_done2;
		end
	end

	// ============================================================
	// register bus write path: address and data taken in either order
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_got_reg    <= 1'b0;
			w_got_reg     <= 1'b0;
			awaddr_q_reg  <= 8'h00;
			wdata_q_reg   <= 32'h0000_0000;
			wstrb_q_reg   <= 4'h0;
			duty_reg      <= DUTY_RST;
		end else begin
			if (s_axi_awready && s_axi_awvalid) begin
				s_axi_awready <= 1'b0;
				aw_got_reg    <= 1'b1;
				awaddr_q_reg  <= s_axi_awaddr;
			end else if (!aw_got_reg && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				s_axi_wready <= 1'b0;
				w_got_reg    <= 1'b1;
				wdata_q_reg  <= s_axi_wdata;
				wstrb_q_reg  <= s_axi_wstrb;
			end else if (!w_got_reg && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if ({awaddr_q_reg[7:2], 2'b00} == REG_CTRL) begin
					s_axi_bresp <= RESP_OKAY;
					if (wstrb_q_reg[0])
						duty_reg <= wdata_q_reg[7:0];
				end else if ({awaddr_q_reg[7:2], 2'b00} == REG_STATUS) begin
					s_axi_bresp <= RESP_OKAY; // read-only, write ignored
				end else if ({awaddr_q_reg[7:2], 2'b00} == REG_LIMIT) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ============================================================
	// register bus read path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			if ({s_axi_araddr[7:2], 2'b00} == REG_CTRL)
				s_axi_rdata <= {24'h00_0000, duty_reg};
			else if ({s_axi_araddr[7:2], 2'b00} == REG_STATUS)
				s_axi_rdata <= {21'h00_0000, st_reg, drv2.low, drv2.high, drv1.low, drv1.high,
					reset_pin_oe_n, ss_done2, ss_done1, lockout};
			else if ({s_axi_araddr[7:2], 2'b00} == REG_LIMIT)
				s_axi_rdata <= {3'h0, thr2_reg, 3'h0, thr1_reg};
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence start1_entry_s;
		$past(st_reg) == SQ_DRAIN && st_reg == SQ_START1;
	endsequence

	lock_drives_a: assert property (lockout |=> !(high_drive_one || low_drive_one ||
		high_drive_two || low_drive_two))
		else $error("drive active during lockout");
	lock_reset_a: assert property (lockout |=> !reset_pin_oe_n)
		else $error("reset released during lockout");
	latch_clear_a: assert property ($fell(lock_reg) |-> $past(cond.rearm))
		else $error("lockout cleared above rearm level");
	two_off_a: assert property (st_reg == SQ_START1 |-> !high_drive_two && !low_drive_two)
		else $error("regulator two driven during first soft-start");
	order_up_a: assert property ((st_reg == SQ_START2 && $past(st_reg) == SQ_START1)
		|-> $past(ss_done1))
		else $error("regulator two started early");
	reset_rel_a: assert property ($rose(reset_pin_oe_n) |->
		$past(cond.lvl1 && cond.lvl2 && ss_done1 && ss_done2))
		else $error("reset released before outputs good");
	order_down_a: assert property (st_reg == SQ_STOP1 |-> ramp2_reg == 8'h00 && !run2)
		else $error("regulator one stopping before two");
	drain_wait_a: assert property (start1_entry_s |-> $past(!need_drain_reg || cond.zero1))
		else $error("restart before output one at zero");
	low_level_a: assert property ((!cond.lvl1 || !cond.lvl2) |=> !reset_pin_oe_n)
		else $error("reset not asserted on low output");

endmodule : dbs_sequencer

// ===== sim/dbs_power_model.sv
// far-side model: power switches and output monitors
`timescale 1ns/1ns
module dbs_power_model (
	// clock and enable seen by the board
	input  wire logic clk,
	input  wire logic en,
	// gate drives
	input  wire logic low_one,
	input  wire logic low_two,
	input  wire logic high_two,
	// sensed back to the device
	output      logic off_one,
	output      logic off_two,
	output      logic ok,
	output      logic zero
);
	// gate charge drains in one clock, so the off sense lags the drive
	always @(posedge clk) begin
		off_one <= !low_one;
		off_two <= !low_two;
	end
	// outputs good once regulator two switched; the low side discharges them,
	// and a discharged output stays at zero until the regulators come up again
	always @(posedge clk) begin
		ok <= en & (ok | high_two);
		zero <= en ? (zero & !ok) : low_one;
	end
endmodule : dbs_power_model

// ===== sim/dual_buck_sequencer_tb.sv
// bench for the dual buck sequencer: bus tasks and power sequences
`timescale 1ns/1ns
module dual_buck_sequencer_tb;
	import dbs_pkg::*;
	logic clk = 1'h0, rst_n = 1'h0, enable = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s1, bad;
	logic [12:0] internal_regulator_supply_mv = 13'h1388, current_sense_one_mv = 13'h0000;
	logic [12:0] limit_setting_pin_one_mv = 13'h07D0, limit_setting_pin_two_mv = 13'h12C0;
	logic [12:0] current_sense_two_mv = 13'h0000;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_rdata;
	logic output_level_one_ok, output_level_one_zero, low_drive_one_off, low_drive_two_off;
	logic high_drive_one, low_drive_one, high_drive_two, low_drive_two, reset_pin_out;
	logic reset_pin_oe_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic output_level_two_ok = output_level_one_ok;
	int n_fail = 0, cmp_count = 0, i, t1, t2;
	// 10 MHz clock
	always #50 clk = ~clk;
	dbs_sequencer dut (.*);
	dbs_power_model far (.clk(clk), .en(enable), .low_one(low_drive_one),
		.low_two(low_drive_two), .high_two(high_drive_two), .off_one(low_drive_one_off),
		.off_two(low_drive_two_off), .ok(output_level_one_ok), .zero(output_level_one_zero));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	// a wait that ran out ends the run as a failure
	task automatic lim(input int n);
		if (i >= n) begin
			n_fail++;
			stop_test();
		end
	endtask : lim
	// each bus task starts after an edge so a stale valid is never taken
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 99 && !s_axi_rvalid; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		lim(99);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rd_reg
	task automatic wr_reg(input logic [7:0] a);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'h0000_0055;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 99 && !s_axi_bvalid; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		lim(99);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr_reg
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (8) @(posedge clk);
		rd_reg(REG_STATUS);
		chk("status", rd, 32'h0000_0100);
		rd_reg(8'h0C);
		chk("bad read", {rd[29:0], rr}, 32'h2);
		wr_reg(8'h0C);
		chk("bad write", rr, 32'h2);
		rd_reg(REG_LIMIT);
		chk("limit", rd, {3'h0, 13'h0064, 3'h0, 13'h00C8});
		enable <= 1'h1;
		s1 = 1'h0;
		bad = 1'h0;
		for (i = 0; i < 4000 && !reset_pin_oe_n; i++) begin
			@(posedge clk);
			s1 = s1 | high_drive_one;
			bad = bad | (high_drive_two & !s1) | (high_drive_one & low_drive_one);
		end
		lim(4000);
		chk("start order", bad, 32'h0);
		current_sense_one_mv <= 13'h01F4;
		// let a high pulse already under way finish before looking for the skip
		repeat (50) @(posedge clk);
		bad = 1'h0;
		repeat (80) @(posedge clk) bad = bad | high_drive_one | !low_drive_one;
		chk("skip", bad, 32'h0);
		current_sense_one_mv <= 13'h0000;
		enable <= 1'h0;
		for (i = 0; i < 1500; i++) begin
			@(posedge clk);
			if (high_drive_one) t1 = i;
			if (high_drive_two) t2 = i;
		end
		chk("stop order", t2 < t1, 32'h1);
		chk("held low", {high_drive_one, low_drive_one, high_drive_two, low_drive_two}, 32'h5);
		enable <= 1'h1;
		s1 = 1'h0;
		repeat (200) @(posedge clk) s1 = s1 | high_drive_one;
		chk("restart", s1, 32'h1);
		internal_regulator_supply_mv <= 13'h0FA0;
		repeat (6) @(posedge clk);
		chk("lock", {high_drive_one, low_drive_one, high_drive_two, low_drive_two, reset_pin_oe_n}, 32'h0);
		internal_regulator_supply_mv <= 13'h1388;
		rd_reg(REG_STATUS);
		chk("latched", rd[0], 32'h1);
		internal_regulator_supply_mv <= 13'h07D0;
		repeat (6) @(posedge clk);
		internal_regulator_supply_mv <= 13'h1388;
		repeat (6) @(posedge clk);
		rd_reg(REG_STATUS);
		chk("rearmed", rd[0], 32'h0);
		stop_test();
	end
endmodule : dual_buck_sequencer_tb
